// >>> dsc_pkg.sv
/*
  Shared constants for the arithmetic slice input and cascade block:
  operand widths, register offsets, control field positions, reset values
  and the codes of the function and carry source selects.
  Assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock.
*/
package dsc_pkg;
  localparam int A_W = 30;
  localparam int B_W = 18;
  localparam int C_W = 48;
  localparam int MA_W = 25;
  localparam int PROD_W = 43;
  localparam int FIELD_W = 12;
  localparam int N_FIELD = 4;
  localparam int FSEL_W = 4;
  localparam int CSEL_W = 3;
  localparam int MODE_W = 5;
  localparam int DEPTH_W = 2;

  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0C;
  localparam logic [7:0] OFS_RES_HI = 8'h10;

  localparam int CFG_A_DEPTH = 0;
  localparam int CFG_B_DEPTH = 2;
  localparam int CFG_A_CASC = 4;
  localparam int CFG_B_CASC = 5;
  localparam int CFG_SPLIT = 6;
  localparam int CFG_USE_PROD = 7;
  localparam int MODE_A1_MULT = 0;
  localparam int MODE_B1_MULT = 4;

  localparam logic [7:0] CFG_RST = 8'h0A;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [1:0] DEPTH_TWO = 2'h2;
  localparam logic [1:0] DEPTH_ZERO = 2'h0;

  localparam logic [FSEL_W-1:0] FN_ADD = 4'h0;
  localparam logic [FSEL_W-1:0] FN_SUB = 4'h3;
  localparam logic [FSEL_W-1:0] FN_XOR = 4'h4;
  localparam logic [FSEL_W-1:0] FN_AND = 4'hC;
  localparam logic [FSEL_W-1:0] FN_OR = 4'hE;

  localparam logic [CSEL_W-1:0] CS_FABRIC = 3'h0;
  localparam logic [CSEL_W-1:0] CS_CHAIN_IN = 3'h1;
  localparam logic [CSEL_W-1:0] CS_FEEDBACK = 3'h2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> dsc_slice.sv
/*
  Input and cascade portion of a multiply-accumulate slice: A/B input
  pipelines with cascade paths, C register, pre-adder result register,
  function select register, carry source selection with cascade and
  feedback, a simple second stage with per-field carries, and an AHB-Lite
  slave for configuration and status.
  Assumes fabric inputs are synchronous to hclk and that the neighbouring
  slices share the same clock.
*/
// The AHB-Lite register port and the register offsets are this design's own decisions.
// Summary of operation
// RULE_01: Multiplier first operand is the low 25 bits of the A path.
// RULE_02: All 30 A bits form the upper part of the A:B word.
// RULE_03: B feeds the multiplier and forms the low 18 bits of A:B.
// RULE_04: A 30-bit A cascade input may replace the direct A operand.
// RULE_05: A 30-bit A cascade output feeds the next slice.
// RULE_06: An 18-bit B cascade input may replace the direct B operand.
// RULE_07: An 18-bit B cascade output feeds the next slice.
// RULE_08: A 4-bit function select chooses the second stage operation.
// RULE_09: The 48-bit C operand reaches the adder and logic function.
// RULE_10: Carry chain input comes from the previous slice, a carry source.
// RULE_11: Carry chain output goes onward and feeds back into the carry mux.
// RULE_12: A 3-bit select picks fabric, chain or feedback carry.
// RULE_13: Four carry bits, one per 12-bit field; split mode uses all.
// RULE_14: First A register loads only while its enable is high.
// RULE_15: Second A register loads only while its enable is high.
// RULE_16: First B register loads only while its enable is high.
// RULE_17: Second B register loads only while its enable is high.
// RULE_18: Pre-adder result register loads only while its enable is high.
// RULE_19: Function select register loads only while its enable is high.
// RULE_20: C register loads only while its enable is high.
// RULE_21: Fabric carry register loads only while its enable is high.
// RULE_22: One clock drives every register of the slice.
// RULE_23: One clear input resets both A registers together.
// RULE_24: One clear input resets both B registers together.
// RULE_25: A separate clear input resets the C register alone.
// RULE_26: With enable low and no clear, a register keeps its value.
// RULE_27: Clears act synchronously on the clock edge and beat enables.
`timescale 1ns/10ps
module dsc_slice (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [dsc_pkg::A_W-1:0] a_operand,
  input wire logic [dsc_pkg::B_W-1:0] b_operand,
  input wire logic [dsc_pkg::C_W-1:0] c_operand,
  input wire logic [dsc_pkg::A_W-1:0] a_cascade_in,
  input wire logic [dsc_pkg::B_W-1:0] b_cascade_in,
  output logic [dsc_pkg::A_W-1:0] a_cascade_out,
  output logic [dsc_pkg::B_W-1:0] b_cascade_out,
  input wire logic [dsc_pkg::FSEL_W-1:0] arith_logic_function_sel,
  input wire logic carry_chain_in,
  output logic carry_chain_out,
  input wire logic fabric_carry_in,
  input wire logic [dsc_pkg::CSEL_W-1:0] carry_source_sel,
  output logic [dsc_pkg::N_FIELD-1:0] field_carry_out,
  output logic [dsc_pkg::C_W-1:0] slice_result,
  input wire logic a_stage1_load_en,
  input wire logic a_stage2_load_en,
  input wire logic b_stage1_load_en,
  input wire logic b_stage2_load_en,
  input wire logic preadd_result_load_en,
  input wire logic function_sel_load_en,
  input wire logic c_operand_load_en,
  input wire logic fabric_carry_load_en,
  input wire logic a_regs_clear,
  input wire logic b_regs_clear,
  input wire logic c_reg_clear
);
  import dsc_pkg::*;

  logic [7:0] cfg_q, cfg_d;
  logic [MODE_W-1:0] mode_q, mode_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q;

  logic [A_W-1:0] a1_q, a1_d, a2_q, a2_d;
  logic [B_W-1:0] b1_q, b1_d, b2_q, b2_d;
  logic [MA_W-1:0] ad_q, ad_d;
  logic [C_W-1:0] c_q, c_d;
  logic [FSEL_W-1:0] fsel_q, fsel_d;
  logic fcarry_q, fcarry_d;
  logic [C_W-1:0] res_q, res_d;
  logic [N_FIELD-1:0] fco_q, fco_d;
  logic chain_q, chain_d;

  logic [DEPTH_W-1:0] a_depth, b_depth;
  logic [A_W-1:0] a_in, a_path, a_mult_src;
  logic [B_W-1:0] b_in, b_path, b_mult;
  logic [MA_W-1:0] a_mult;
  logic [PROD_W-1:0] prod;
  logic [C_W-1:0] x_op, x_eff, logic_res;
  logic cin_sel, cin0, is_sub, is_arith;
  logic [FIELD_W:0] fsum [N_FIELD];
  logic [N_FIELD:0] fci;

  assign a_depth = cfg_q[CFG_A_DEPTH +: DEPTH_W];
  assign b_depth = cfg_q[CFG_B_DEPTH +: DEPTH_W];

  // Register bus. Writes complete in the data phase with no wait state.
  always_comb begin
    cfg_d = cfg_q;
    mode_d = mode_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    rdata_d = rdata_q;
    if (wr_pend_q) begin
      if (wr_addr_q == OFS_CFG) begin
        cfg_d = hwdata[7:0];
      end else if (wr_addr_q == OFS_MODE) begin
        mode_d = hwdata[MODE_W-1:0];
      end
    end
    if (hready && hsel && htrans == HTRANS_NONSEQ) begin
      wr_pend_d = hwrite;
      wr_addr_d = haddr[7:0];
      if (haddr[7:0] == OFS_CFG) begin
        rdata_d = {24'h000000, cfg_q};
      end else if (haddr[7:0] == OFS_MODE) begin
        rdata_d = {27'h0000000, mode_q};
      end else if (haddr[7:0] == OFS_STATUS) begin
        rdata_d = {27'h0000000, chain_q, fco_q};
      end else if (haddr[7:0] == OFS_RES_LO) begin
        rdata_d = res_q[31:0];
      end else if (haddr[7:0] == OFS_RES_HI) begin
        rdata_d = {16'h0000, res_q[47:32]};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CFG_RST;
      mode_q <= MODE_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      ready_q <= 1'b1;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = 1'b0;

  // Operand sources and the A and B input pipelines.
  always_comb begin
    a_in = cfg_q[CFG_A_CASC] ? a_cascade_in : a_operand; // [RULE_04]
    b_in = cfg_q[CFG_B_CASC] ? b_cascade_in : b_operand; // [RULE_06]
    a_path = (a_depth == DEPTH_ZERO) ? a_in : a2_q;
    b_path = (b_depth == DEPTH_ZERO) ? b_in : b2_q;
    // The first stage may bypass the second for the multiplier only.
    a_mult_src = mode_q[MODE_A1_MULT] ? a1_q : a_path;
    b_mult = mode_q[MODE_B1_MULT] ? b1_q : b_path; // [RULE_03]
    a_mult = a_mult_src[MA_W-1:0]; // [RULE_01]
    a1_d = a1_q; // [RULE_26]
    a2_d = a2_q;
    b1_d = b1_q;
    b2_d = b2_q;
    if (a_regs_clear) begin // [RULE_23] [RULE_27]
      a1_d = '0;
      a2_d = '0;
    end else begin
      if (a_stage1_load_en) begin // [RULE_14]
        a1_d = a_in;
      end
      if (a_stage2_load_en) begin // [RULE_15]
        a2_d = (a_depth == DEPTH_TWO) ? a1_q : a_in;
      end
    end
    if (b_regs_clear) begin // [RULE_24] [RULE_27]
      b1_d = '0;
      b2_d = '0;
    end else begin
      if (b_stage1_load_en) begin // [RULE_16]
        b1_d = b_in;
      end
      if (b_stage2_load_en) begin // [RULE_17]
        b2_d = (b_depth == DEPTH_TWO) ? b1_q : b_in;
      end
    end
    ad_d = preadd_result_load_en ? a_mult : ad_q; // [RULE_18]
    fsel_d = function_sel_load_en ? arith_logic_function_sel
                                  : fsel_q; // [RULE_19]
    fcarry_d = fabric_carry_load_en ? fabric_carry_in
                                    : fcarry_q; // [RULE_21]
    if (c_reg_clear) begin // [RULE_25] [RULE_27]
      c_d = '0;
    end else begin
      c_d = c_operand_load_en ? c_operand : c_q; // [RULE_20]
    end
  end

  assign prod = PROD_W'($signed(ad_q) * $signed(b_mult));

  // Second stage: C against A:B or the product, field by field.
  always_comb begin
    x_op = cfg_q[CFG_USE_PROD] ? {{(C_W-PROD_W){prod[PROD_W-1]}}, prod}
                               : {a_path, b_path}; // [RULE_02] [RULE_03]
    is_sub = (fsel_q == FN_SUB);
    is_arith = (fsel_q == FN_ADD) || is_sub; // [RULE_08]
    x_eff = is_sub ? ~x_op : x_op;
    if (carry_source_sel == CS_FABRIC) begin // [RULE_12]
      cin_sel = fcarry_q;
    end else if (carry_source_sel == CS_CHAIN_IN) begin
      cin_sel = carry_chain_in; // [RULE_10]
    end else if (carry_source_sel == CS_FEEDBACK) begin
      cin_sel = chain_q; // [RULE_11]
    end else begin
      cin_sel = 1'b0;
    end
    // Subtract forms C - (X + carry) as C + ~X + ~carry.
    cin0 = is_sub ? ~cin_sel : cin_sel;
    if (fsel_q == FN_AND) begin
      logic_res = c_q & x_op; // [RULE_09]
    end else if (fsel_q == FN_OR) begin
      logic_res = c_q | x_op;
    end else begin
      logic_res = c_q ^ x_op;
    end
  end

  assign fci[0] = cin0;
  for (genvar f = 0; f < N_FIELD; f++) begin : g_field
    // In split mode every field starts from the selected carry.
    assign fsum[f] = {1'b0, c_q[f*FIELD_W +: FIELD_W]}
                   + {1'b0, x_eff[f*FIELD_W +: FIELD_W]}
                   + {{FIELD_W{1'b0}}, fci[f]};
    assign fci[f+1] = cfg_q[CFG_SPLIT] ? cin0 : fsum[f][FIELD_W];
    assign res_d[f*FIELD_W +: FIELD_W] = is_arith ?
      fsum[f][FIELD_W-1:0] : logic_res[f*FIELD_W +: FIELD_W];
    assign fco_d[f] = is_arith & fsum[f][FIELD_W]; // [RULE_13]
  end
  assign chain_d = fco_d[N_FIELD-1]; // [RULE_11]

  // Slice clears are synchronous; hresetn only brings the part up.
  always_ff @(posedge hclk or negedge hresetn) begin // [RULE_22]
    if (!hresetn) begin
      a1_q <= '0;
      a2_q <= '0;
      b1_q <= '0;
      b2_q <= '0;
      ad_q <= '0;
      c_q <= '0;
      fsel_q <= FN_ADD;
      fcarry_q <= 1'b0;
      res_q <= '0;
      fco_q <= '0;
      chain_q <= 1'b0;
    end else begin
      a1_q <= a1_d;
      a2_q <= a2_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      ad_q <= ad_d;
      c_q <= c_d;
      fsel_q <= fsel_d;
      fcarry_q <= fcarry_d;
      res_q <= res_d;
      fco_q <= fco_d;
      chain_q <= chain_d;
    end
  end

  assign a_cascade_out = a2_q; // [RULE_05]
  assign b_cascade_out = b2_q; // [RULE_07]
  assign carry_chain_out = chain_q; // [RULE_11]
  assign field_carry_out = fco_q; // [RULE_13]
  assign slice_result = res_q;

  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_a1_load;
    !a_regs_clear && a_stage1_load_en |=> a1_q == $past(a_in);
  endproperty
  a_a1_load: assert property (p_a1_load) // [RULE_14]
    else $error("first A register missed a load");

  property p_a2_hold;
    !a_regs_clear && !a_stage2_load_en |=> $stable(a2_q);
  endproperty
  a_a2_hold: assert property (p_a2_hold) // [RULE_15]
    else $error("second A register changed without enable");

  property p_b1_hold;
    !b_regs_clear && !b_stage1_load_en ##1
      !b_regs_clear && !b_stage1_load_en |=> b1_q == $past(b1_q, 2);
  endproperty
  a_b1_hold: assert property (p_b1_hold) // [RULE_16]
    else $error("first B register changed without enable");

  property p_b2_load;
    !b_regs_clear && b_stage2_load_en && b_depth != DEPTH_TWO
      |=> b2_q == $past(b_in);
  endproperty
  a_b2_load: assert property (p_b2_load) // [RULE_17]
    else $error("second B register missed a load");

  property p_ad_hold;
    !preadd_result_load_en |=> ad_q == $past(ad_q);
  endproperty
  a_ad_hold: assert property (p_ad_hold) // [RULE_18]
    else $error("pre-adder register changed without enable");

  property p_fsel;
    function_sel_load_en |=> fsel_q == $past(arith_logic_function_sel);
  endproperty
  a_fsel: assert property (p_fsel) // [RULE_19]
    else $error("function select register missed a load");

  property p_c_load;
    c_operand_load_en && !c_reg_clear |=> c_q == $past(c_operand);
  endproperty
  a_c_load: assert property (p_c_load) // [RULE_20]
    else $error("C register missed a load");

  property p_fcarry_hold;
    !fabric_carry_load_en |=> $stable(fcarry_q);
  endproperty
  a_fcarry_hold: assert property (p_fcarry_hold) // [RULE_21]
    else $error("fabric carry register changed without enable");

  property p_a_clear;
    a_regs_clear |=> a1_q == '0 && a2_q == '0;
  endproperty
  a_a_clear: assert property (p_a_clear) // [RULE_23]
    else $error("A clear did not zero both A registers");

  property p_b_clear;
    b_regs_clear |=> b1_q == '0 && b2_q == '0;
  endproperty
  a_b_clear: assert property (p_b_clear) // [RULE_24]
    else $error("B clear did not zero both B registers");

  property p_c_clear;
    c_reg_clear && c_operand_load_en |=> c_q == '0;
  endproperty
  a_c_clear: assert property (p_c_clear) // [RULE_25]
    else $error("C clear lost to the load enable");

  property p_casc;
    a_stage2_load_en && !a_regs_clear |=> a_cascade_out ==
      $past((a_depth == DEPTH_TWO) ? a1_q : a_in);
  endproperty
  a_casc: assert property (p_casc) // [RULE_05]
    else $error("A cascade output not the second A stage");

  property p_chain_top;
    carry_source_sel == CS_FEEDBACK |-> cin_sel == carry_chain_out;
  endproperty
  a_chain_top: assert property (p_chain_top) // [RULE_11]
    else $error("feedback carry is not the own chain output");

  c_split: cover property (cfg_q[CFG_SPLIT] && fco_d == 4'hF);
  c_casc: cover property (cfg_q[CFG_A_CASC] && a_stage2_load_en);
  c_feedback: cover property (carry_source_sel == CS_FEEDBACK && chain_q);
  c_clear_load: cover property (a_regs_clear && a_stage1_load_en);
endmodule

// >>> dsc_nbr.sv
/*
  Model of the preceding slice in the column: its registered A, B and
  carry cascade outputs.
  Assumes the same hclk and hresetn as the slice under test.
*/
`timescale 1ns/10ps
module dsc_nbr (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load_en,
  input wire logic [dsc_pkg::A_W-1:0] a_next,
  input wire logic [dsc_pkg::B_W-1:0] b_next,
  input wire logic carry_next,
  output logic [dsc_pkg::A_W-1:0] a_cascade_out,
  output logic [dsc_pkg::B_W-1:0] b_cascade_out,
  output logic carry_chain_out
);
  import dsc_pkg::*;
  // Outputs hold between loads, as real registers would.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_cascade_out <= '0;
      b_cascade_out <= '0;
      carry_chain_out <= 1'b0;
    end else if (load_en) begin
      a_cascade_out <= a_next;
      b_cascade_out <= b_next;
      carry_chain_out <= carry_next;
    end
  end
endmodule

// >>> dsc_tb.sv
/*
  Self-checking bench for the slice: random datapath traffic against a
  reference model, register access over AHB-Lite, two resets.
  Assumes hready is the slice's own hreadyout.
*/
`timescale 1ns/10ps
module tb;
  import dsc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp;
  logic [A_W-1:0] a_op = '0, pa_n = '0, a_ci, a_co, m_a1, m_a2, asrc;
  logic [B_W-1:0] b_op = '0, pb_n = '0, b_ci, b_co, m_b1, m_b2, bsrc;
  logic [C_W-1:0] c_op = '0, res, m_c, m_res;
  logic [C_W-1:0] x;
  logic [A_W-1:0] apath;
  logic [B_W-1:0] bpath, bm;
  logic [PROD_W-1:0] prd;
  logic [MA_W-1:0] m_ad;
  logic [MODE_W-1:0] m_mode, mode;
  logic [FSEL_W-1:0] fsel = '0, m_fn;
  logic [CSEL_W-1:0] csel = '0;
  logic [N_FIELD-1:0] fco, m_fc;
  logic [7:0] en = '0, m_cfg, cfg;
  logic [2:0] clr = '0;
  logic fcin = 1'b0, pc_n = 1'b0, p_en = 1'b0, c_ci, cco, m_cf, cin;
  int errors = 0;
  int samples_checked = 0;
  int unsigned seed;

  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  dsc_nbr prev (.hclk(hclk), .hresetn(hresetn), .load_en(p_en),
    .a_next(pa_n), .b_next(pb_n), .carry_next(pc_n),
    .a_cascade_out(a_ci), .b_cascade_out(b_ci), .carry_chain_out(c_ci));

  dsc_slice dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .a_operand(a_op),
    .b_operand(b_op), .c_operand(c_op), .a_cascade_in(a_ci),
    .b_cascade_in(b_ci), .a_cascade_out(a_co), .b_cascade_out(b_co),
    .arith_logic_function_sel(fsel), .carry_chain_in(c_ci),
    .carry_chain_out(cco), .fabric_carry_in(fcin),
    .carry_source_sel(csel), .field_carry_out(fco), .slice_result(res),
    .a_stage1_load_en(en[0]), .a_stage2_load_en(en[1]),
    .b_stage1_load_en(en[2]), .b_stage2_load_en(en[3]),
    .preadd_result_load_en(en[4]), .function_sel_load_en(en[5]),
    .c_operand_load_en(en[6]), .fabric_carry_load_en(en[7]),
    .a_regs_clear(clr[0]), .b_regs_clear(clr[1]), .c_reg_clear(clr[2]));

  // Second stage: returns {field carries, result}.
  function automatic logic [51:0] calc(input logic [C_W-1:0] c, x,
      input logic [FSEL_W-1:0] fn, input logic ci, split);
    logic [C_W-1:0] xo, r;
    logic [12:0] s;
    logic [3:0] fc;
    logic cb, cy;
    int f;
    xo = (fn == FN_SUB) ? ~x : x;
    cb = (fn == FN_SUB) ? ~ci : ci;
    cy = cb;
    for (f = 0; f < N_FIELD; f++) begin
      s = {1'b0, c[f*FIELD_W+:FIELD_W]} + {1'b0, xo[f*FIELD_W+:FIELD_W]}
        + 13'(cy);
      r[f*FIELD_W+:FIELD_W] = s[11:0];
      fc[f] = s[12];
      cy = split ? cb : s[12];
    end
    if (fn != FN_ADD && fn != FN_SUB) begin
      fc = '0;
      r = (fn == FN_AND) ? (c & x) : (fn == FN_OR) ? (c | x) : (c ^ x);
    end
    return {fc, r};
  endfunction

  // Reference model; every next value is taken from the old state.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {m_a1, m_a2, m_b1, m_b2, m_c, m_res, m_fc} = '0;
      m_ad = '0;
      m_mode = MODE_RST;
      m_fn = FN_ADD;
      m_cf = 1'b0;
      m_cfg = CFG_RST;
    end else begin
      cin = (csel == CS_FABRIC) ? m_cf : (csel == CS_CHAIN_IN) ? c_ci :
        (csel == CS_FEEDBACK) ? m_fc[3] : 1'b0;
      asrc = m_cfg[CFG_A_CASC] ? a_ci : a_op;
      bsrc = m_cfg[CFG_B_CASC] ? b_ci : b_op;
      apath = (m_cfg[1:0] == DEPTH_ZERO) ? asrc : m_a2;
      bpath = (m_cfg[3:2] == DEPTH_ZERO) ? bsrc : m_b2;
      bm = m_mode[MODE_B1_MULT] ? m_b1 : bpath;
      prd = PROD_W'($signed(m_ad) * $signed(bm));
      x = m_cfg[CFG_USE_PROD] ? C_W'($signed(prd)) : {apath, bpath};
      {m_fc, m_res} = calc(m_c, x, m_fn, cin, m_cfg[CFG_SPLIT]);
      // Only the low 25 bits of the chosen A value reach the multiplier.
      if (en[4]) m_ad = MA_W'(m_mode[MODE_A1_MULT] ? m_a1 : apath);
      if (clr[0]) m_a2 = '0;
      else if (en[1]) m_a2 = (m_cfg[1:0] == DEPTH_TWO) ? m_a1 : asrc;
      if (clr[0]) m_a1 = '0;
      else if (en[0]) m_a1 = asrc;
      if (clr[1]) m_b2 = '0;
      else if (en[3]) m_b2 = (m_cfg[3:2] == DEPTH_TWO) ? m_b1 : bsrc;
      if (clr[1]) m_b1 = '0;
      else if (en[2]) m_b1 = bsrc;
      if (clr[2]) m_c = '0;
      else if (en[6]) m_c = c_op;
      if (en[5]) m_fn = fsel;
      if (en[7]) m_cf = fcin;
    end
  end

  task automatic miss(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  always @(negedge hclk) begin
    if (hresetn === 1'b1) begin
      samples_checked += 5;
      if (a_co !== m_a2) miss("a cascade out");
      if (b_co !== m_b2) miss("b cascade out");
      if (res !== m_res) miss("result");
      if (fco !== m_fc) miss("field carries");
      if (cco !== m_fc[3]) miss("chain carry");
    end else if (hresetn === 1'b0) begin
      samples_checked++;
      if (hreadyout !== 1'b0 || res !== '0) miss("reset state");
    end
  end

  // Each read made here is compared by the caller.
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    if (hresp !== 1'b0) miss("error response");
    if (!w) samples_checked++;
  endtask

  task automatic drive_rand();
    a_op <= A_W'($urandom);
    b_op <= B_W'($urandom);
    // All-ones C now and then forces long carry ripples.
    c_op <= ($urandom_range(7) == 0) ? '1 : C_W'({$urandom, $urandom});
    pa_n <= A_W'($urandom);
    pb_n <= B_W'($urandom);
    pc_n <= 1'($urandom);
    p_en <= 1'($urandom);
    en <= 8'($urandom);
    clr <= ($urandom_range(3) == 0) ? 3'($urandom) : 3'h0;
    fsel <= 4'($urandom);
    csel <= 3'($urandom);
    fcin <= 1'($urandom);
  endtask

  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    miss("watchdog expired");
    summarize();
  end

  initial begin
    seed = $urandom(21743);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFS_CFG, 32'h0, rd);
    if (rd !== {24'h0, CFG_RST}) miss("cfg reset value");
    ahb(1'b0, OFS_MODE, 32'h0, rd);
    if (rd !== {27'h0, MODE_RST}) miss("mode reset value");
    for (int blk = 0; blk < 8; blk++) begin
      cfg = {2'($urandom), 2'($urandom), 2'($urandom_range(2, 0)),
        2'($urandom_range(2, 0))};
      cfg[CFG_SPLIT] = blk[0];
      mode = 5'($urandom);
      ahb(1'b1, OFS_CFG, {24'h0, cfg}, rd);
      m_cfg <= cfg;
      ahb(1'b1, OFS_MODE, {27'h0, mode}, rd);
      m_mode <= mode;
      ahb(1'b0, OFS_CFG, 32'h0, rd);
      if (rd !== {24'h0, cfg}) miss("cfg readback");
      ahb(1'b0, OFS_MODE, 32'h0, rd);
      if (rd !== {27'h0, mode}) miss("mode readback");
      repeat (300) begin
        @(posedge hclk);
        drive_rand();
      end
      // Clearing the pipelines hides first-stage state that is unused at
      // depth one, so the next configuration starts from a known point.
      @(posedge hclk);
      en <= '0;
      clr <= 3'h7;
      csel <= CS_FABRIC;
      repeat (3) @(posedge hclk);
      ahb(1'b0, OFS_RES_LO, 32'h0, rd);
      if (rd !== m_res[31:0]) miss("result low");
      ahb(1'b0, OFS_RES_HI, 32'h0, rd);
      if (rd !== {16'h0, m_res[47:32]}) miss("result high");
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      if (rd !== {27'h0, m_fc[3], m_fc}) miss("status");
    end
    ahb(1'b1, OFS_STATUS, 32'hFFFFFFFF, rd);
    ahb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    if (rd !== 32'h0) miss("unmapped read");
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    if (rd !== {27'h0, m_fc[3], m_fc}) miss("status write");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFS_CFG, 32'h0, rd);
    if (rd !== {24'h0, CFG_RST}) miss("cfg after reset");
    summarize();
  end
endmodule
